// ===== hdl/dyam_map.svh
// Register offsets, field positions, reset values and timing counts of the alarm monitor.
`ifndef DYAM_MAP_SVH
`define DYAM_MAP_SVH

// ----------------------------------------------------------------
// Register indices and byte addresses
// ----------------------------------------------------------------
`define DYAM_IDX_IRQ_CONTROL 8'h00
`define DYAM_IDX_BLOCK_IRQ_ENABLE 8'h01
`define DYAM_IDX_ALARM_ERROR_STATUS 8'h02
`define DYAM_IDX_ALARM_ERROR_IRQ_ENABLE 8'h03
`define DYAM_ADDR_IRQ_CONTROL 8'h00
`define DYAM_ADDR_BLOCK_IRQ_ENABLE 8'h04
`define DYAM_ADDR_ALARM_ERROR_STATUS 8'h08
`define DYAM_ADDR_ALARM_ERROR_IRQ_ENABLE 8'h0C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define DYAM_BIT_CLEAR_ON_READ 0
`define DYAM_BIT_ALARM_GROUP_EN 1
`define DYAM_BIT_FAR_END_CHG_EN 0
`define DYAM_BIT_FAR_END_CHG 0
`define DYAM_BIT_FAR_END_STATE 5

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define DYAM_RST_IRQ_CONTROL 8'h00
`define DYAM_RST_BLOCK_IRQ_ENABLE 8'h00
`define DYAM_RST_ALARM_ERROR_IRQ_ENABLE 8'h00

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define DYAM_CLK_PERIOD_NS 5
`define DYAM_INTERVAL_NS 6000000
`define DYAM_INTERVAL_CYCLES (`DYAM_INTERVAL_NS / `DYAM_CLK_PERIOD_NS)
`define DYAM_DECLARE_COUNT 80

`endif

// ===== hdl/dyam_pkg.sv
// Types shared by the alarm monitor modules.
package dyam_pkg;
    typedef enum logic [1:0] {
        DYAM_RESP_OKAY = 2'h0,
        DYAM_RESP_SLVERR = 2'h2
    } dyam_resp_e;
    typedef logic [7:0] dyam_reg_t;
endpackage : dyam_pkg

// ===== hdl/dyam_if.sv
// Carrier between the interval integrator and the register block.
`timescale 1ns/1ps
interface dyam_if #(parameter int CNT_W = 7);
    logic interval_tick;
    logic far_end_alarm;
    logic alarm_change;
    logic [CNT_W-1:0] count;
    modport integ (output interval_tick, output far_end_alarm, output alarm_change, output count);
    modport ctrl (input interval_tick, input far_end_alarm, input alarm_change, input count);
endinterface : dyam_if

// ===== hdl/dyam_integrator.sv
// Interval timer and up/down interval counter that declare and remove the far-end alarm.
`timescale 1ns/1ps
`include "dyam_map.svh"
module dyam_integrator #(
    parameter int unsigned INTERVAL_CYCLES = `DYAM_INTERVAL_CYCLES,
    parameter int unsigned DECLARE_COUNT = `DYAM_DECLARE_COUNT
) (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Pattern detector strobe.
    input wire logic pattern_seen,
    // Results toward the register block.
    dyam_if.integ link
);
    import dyam_pkg::*;

    localparam int TW = (INTERVAL_CYCLES > 1) ? $clog2(INTERVAL_CYCLES) : 1;
    localparam int CW = $clog2(DECLARE_COUNT + 1);

    logic [TW-1:0] timer;
    logic flagged;
    logic [CW-1:0] count;
    logic alarm;
    logic change;
    logic tick;
    logic [TW-1:0] next_timer;
    logic [CW-1:0] next_count;
    logic next_alarm;

    // ----------------------------------------------------------------
    // Interval divider and flag
    // ----------------------------------------------------------------
    // A pattern seen in the closing cycle still counts for that interval.
    wire timer_end = (timer == TW'(INTERVAL_CYCLES - 1));
    wire interval_flag = flagged | pattern_seen;
    wire at_top = (count == CW'(DECLARE_COUNT));
    wire at_zero = (count == '0);
    assign next_timer = timer_end ? '0 : timer + 1'b1;

    // Counter saturates at both ends so a long alarm needs no longer recovery.
    assign next_count = !timer_end ? count :
                        interval_flag ? (at_top ? count : count + 1'b1) : // RL2
                        (at_zero ? count : count - 1'b1); // RL3
    assign next_alarm = (next_count == CW'(DECLARE_COUNT)) ? 1'b1 : // RL2
                        (next_count == '0) ? 1'b0 : alarm; // RL3

    // Timer, flag and tick register.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer <= '0;
            flagged <= 1'b0;
            tick <= 1'b0;
        end else begin
            timer <= next_timer; // RL1
            flagged <= timer_end ? 1'b0 : interval_flag; // RL1
            tick <= timer_end;
        end
    end

    // Counter and alarm state with a one-cycle change pulse.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count <= '0;
            alarm <= 1'b0;
            change <= 1'b0;
        end else begin
            count <= next_count;
            alarm <= next_alarm;
            change <= next_alarm != alarm;
        end
    end

    assign link.interval_tick = tick;
    assign link.far_end_alarm = alarm;
    assign link.alarm_change = change;
    assign link.count = count;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_flag_held;
        @(posedge aclk) disable iff (!aresetn)
        pattern_seen && !timer_end |=> flagged;
    endproperty
    a_flag_held: assert property (p_flag_held) else $error("Pattern not flagged."); // RL1

    property p_declare;
        @(posedge aclk) disable iff (!aresetn)
        timer_end && interval_flag && count == CW'(DECLARE_COUNT - 1) |=> alarm && at_top;
    endproperty
    a_declare: assert property (p_declare) else $error("Alarm not declared at top."); // RL2

    property p_remove;
        @(posedge aclk) disable iff (!aresetn)
        $fell(alarm) |-> at_zero && $past(timer_end);
    endproperty
    a_remove: assert property (p_remove) else $error("Alarm removed above zero."); // RL3

    property p_down;
        @(posedge aclk) disable iff (!aresetn)
        timer_end && !interval_flag && !at_zero |=> count == $past(count) - 1'b1;
    endproperty
    a_down: assert property (p_down) else $error("Clean interval did not count down."); // RL3
endmodule : dyam_integrator

// ===== hdl/dyam_monitor.sv
// Far-end alarm monitor with AXI4-Lite register block and interrupt.
`timescale 1ns/1ps
`include "dyam_map.svh"

// Contract
// RL1 - Time is cut into 6 ms intervals; any pattern sighting flags the interval.
// RL2 - Flagged intervals count up; alarm is declared at 80.
// RL3 - Clean intervals count down; a declared alarm clears only at zero.
// RL4 - Change-enable bit 0 set lets declaration and removal interrupt.
// RL5 - Change-enable bit 0 clear blocks all far-end alarm interrupts.
// RL6 - Block enable bit 1 gates every alarm-group interrupt.
// RL7 - Status bit 5 reads the current far-end alarm state.
// RL8 - Status bit 0 latches on every state change until cleared.
// RL9 - With clear-on-read set, reading status clears bit 0 and its interrupt.
// RL10 - Without clear-on-read, software clears bit 0 by writing one.
// RL11 - Interrupt is high while bit 0, its enable and master enable are set.
module dyam_monitor #(
    parameter int unsigned INTERVAL_CYCLES = `DYAM_INTERVAL_CYCLES,
    parameter int unsigned DECLARE_COUNT = `DYAM_DECLARE_COUNT,
    parameter int ADDR_W = 8
) (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Pattern detector.
    input wire logic pattern_seen,
    // AXI4-Lite write address.
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    // AXI4-Lite write data.
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // AXI4-Lite write response.
    output dyam_pkg::dyam_resp_e bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read address.
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    // AXI4-Lite read data.
    output logic [31:0] rdata,
    output dyam_pkg::dyam_resp_e rresp,
    output logic rvalid,
    input wire logic rready,
    // Interrupt.
    output logic irq
);
    import dyam_pkg::*;

    localparam int CW = $clog2(DECLARE_COUNT + 1);

    // Matches a bus address against a register byte address.
    function automatic logic addr_is(input logic [ADDR_W-1:0] addr, input logic [7:0] reg_addr);
        addr_is = (addr == ADDR_W'(reg_addr));
    endfunction : addr_is

    // Tells whether an address names any register.
    function automatic logic addr_mapped(input logic [ADDR_W-1:0] addr);
        addr_mapped = addr_is(addr, `DYAM_ADDR_IRQ_CONTROL)
                    | addr_is(addr, `DYAM_ADDR_BLOCK_IRQ_ENABLE)
                    | addr_is(addr, `DYAM_ADDR_ALARM_ERROR_STATUS)
                    | addr_is(addr, `DYAM_ADDR_ALARM_ERROR_IRQ_ENABLE);
    endfunction : addr_mapped

    dyam_if #(.CNT_W(CW)) link ();

    dyam_integrator #(
        .INTERVAL_CYCLES(INTERVAL_CYCLES),
        .DECLARE_COUNT(DECLARE_COUNT)
    ) u_integrator (
        .aclk(aclk),
        .aresetn(aresetn),
        .pattern_seen(pattern_seen),
        .link(link)
    );

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    dyam_reg_t irq_control;
    dyam_reg_t block_irq_enable;
    dyam_reg_t alarm_error_irq_enable;
    logic far_end_chg;
    logic next_far_end_chg;

    // ----------------------------------------------------------------
    // Write channel holding
    // ----------------------------------------------------------------
    logic aw_full;
    logic w_full;
    logic [ADDR_W-1:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic next_aw_full;
    logic next_w_full;
    logic next_bvalid;

    // Address and data are taken in either order; the write commits once both wait.
    wire aw_hs = awvalid & awready;
    wire w_hs = wvalid & wready;
    wire commit = aw_full & w_full & ~bvalid;
    assign next_aw_full = (aw_full | aw_hs) & ~commit;
    assign next_w_full = (w_full | w_hs) & ~commit;
    assign next_bvalid = commit | (bvalid & ~bready);

    // Write decode.
    wire wr_ok = addr_mapped(aw_addr_q);
    wire wr_go = commit & wr_ok & w_strb_q[0];
    wire wr_ctl = wr_go & addr_is(aw_addr_q, `DYAM_ADDR_IRQ_CONTROL);
    wire wr_block_irq_enable = wr_go & addr_is(aw_addr_q, `DYAM_ADDR_BLOCK_IRQ_ENABLE);
    wire wr_stat = wr_go & addr_is(aw_addr_q, `DYAM_ADDR_ALARM_ERROR_STATUS);
    wire wr_aeie = wr_go & addr_is(aw_addr_q, `DYAM_ADDR_ALARM_ERROR_IRQ_ENABLE);

    // Handshake state of the write side.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= DYAM_RESP_OKAY;
        end else begin
            aw_full <= next_aw_full;
            w_full <= next_w_full;
            awready <= ~next_aw_full & ~next_bvalid;
            wready <= ~next_w_full & ~next_bvalid;
            bvalid <= next_bvalid;
            if (commit) begin
                bresp <= wr_ok ? DYAM_RESP_OKAY : DYAM_RESP_SLVERR;
            end
        end
    end

    // Payload capture needs no reset; it is only read after a handshake.
    always_ff @(posedge aclk) begin
        if (aw_hs) begin
            aw_addr_q <= awaddr;
        end
        if (w_hs) begin
            w_data_q <= wdata;
            w_strb_q <= wstrb;
        end
    end

    // ----------------------------------------------------------------
    // Read channel
    // ----------------------------------------------------------------
    logic next_rvalid;
    dyam_reg_t rd_byte;

    wire ar_hs = arvalid & arready;
    wire rd_ok = addr_mapped(araddr);
    wire rd_stat = addr_is(araddr, `DYAM_ADDR_ALARM_ERROR_STATUS);
    wire clear_on_read = irq_control[`DYAM_BIT_CLEAR_ON_READ];
    wire rd_clear = ar_hs & rd_stat & clear_on_read; // RL9
    assign next_rvalid = ar_hs | (rvalid & ~rready);

    // Read data selection; unmapped addresses read zero.
    always_comb begin
        rd_byte = 8'h00;
        if (addr_is(araddr, `DYAM_ADDR_IRQ_CONTROL)) begin
            rd_byte = irq_control;
        end else if (addr_is(araddr, `DYAM_ADDR_BLOCK_IRQ_ENABLE)) begin
            rd_byte = block_irq_enable;
        end else if (rd_stat) begin
            rd_byte[`DYAM_BIT_FAR_END_STATE] = link.far_end_alarm; // RL7
            rd_byte[`DYAM_BIT_FAR_END_CHG] = far_end_chg;
        end else if (addr_is(araddr, `DYAM_ADDR_ALARM_ERROR_IRQ_ENABLE)) begin
            rd_byte = alarm_error_irq_enable;
        end
    end

    // Read response register.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= DYAM_RESP_OKAY;
        end else begin
            arready <= ~next_rvalid;
            rvalid <= next_rvalid;
            if (ar_hs) begin
                rdata <= {24'h000000, rd_byte};
                rresp <= rd_ok ? DYAM_RESP_OKAY : DYAM_RESP_SLVERR;
            end
        end
    end

    // ----------------------------------------------------------------
    // Control registers and the change flag
    // ----------------------------------------------------------------
    // A change in the same cycle as a clear wins, so no event is lost.
    wire wr_w1c = wr_stat & w_data_q[`DYAM_BIT_FAR_END_CHG]; // RL10
    assign next_far_end_chg = link.alarm_change | (far_end_chg & ~(wr_w1c | rd_clear)); // RL8

    // Software-owned registers and the latched change bit.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_control <= `DYAM_RST_IRQ_CONTROL;
            block_irq_enable <= `DYAM_RST_BLOCK_IRQ_ENABLE;
            alarm_error_irq_enable <= `DYAM_RST_ALARM_ERROR_IRQ_ENABLE;
            far_end_chg <= 1'b0;
        end else begin
            if (wr_ctl) begin
                irq_control <= w_data_q[7:0];
            end
            if (wr_block_irq_enable) begin
                block_irq_enable <= w_data_q[7:0];
            end
            if (wr_aeie) begin
                alarm_error_irq_enable <= w_data_q[7:0];
            end
            far_end_chg <= next_far_end_chg; // RL8
        end
    end

    // ----------------------------------------------------------------
    // Interrupt
    // ----------------------------------------------------------------
    // The output is registered, so it trails the status bit by one cycle.
    wire chg_en = alarm_error_irq_enable[`DYAM_BIT_FAR_END_CHG_EN]; // RL4 RL5
    wire group_en = block_irq_enable[`DYAM_BIT_ALARM_GROUP_EN]; // RL6
    wire next_irq = far_end_chg & chg_en & group_en; // RL11

    // Interrupt output flop.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= next_irq; // RL11
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_irq_on;
        @(posedge aclk) disable iff (!aresetn)
        far_end_chg && chg_en && group_en |=> irq;
    endproperty
    a_irq_on: assert property (p_irq_on) else $error("Enabled change raised no interrupt."); // RL4

    property p_irq_masked;
        @(posedge aclk) disable iff (!aresetn)
        !chg_en |=> !irq;
    endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("Interrupt while disabled."); // RL5

    property p_irq_group;
        @(posedge aclk) disable iff (!aresetn)
        !group_en |=> !irq;
    endproperty
    a_irq_group: assert property (p_irq_group) else $error("Interrupt past master gate."); // RL6

    property p_state_read;
        @(posedge aclk) disable iff (!aresetn)
        ar_hs && rd_stat |=> rvalid && rdata[`DYAM_BIT_FAR_END_STATE] == $past(link.far_end_alarm);
    endproperty
    a_state_read: assert property (p_state_read) else $error("State bit misread."); // RL7

    property p_chg_latch;
        @(posedge aclk) disable iff (!aresetn)
        link.alarm_change |=> far_end_chg;
    endproperty
    a_chg_latch: assert property (p_chg_latch) else $error("Change not latched."); // RL8

    property p_clear_read;
        @(posedge aclk) disable iff (!aresetn)
        rd_clear && !link.alarm_change |=> !far_end_chg ##1 !irq;
    endproperty
    a_clear_read: assert property (p_clear_read) else $error("Read did not clear."); // RL9

    property p_read_keeps;
        @(posedge aclk) disable iff (!aresetn)
        far_end_chg && !clear_on_read && !wr_w1c |=> far_end_chg;
    endproperty
    a_read_keeps: assert property (p_read_keeps) else $error("Change bit lost."); // RL10

    property p_w1c;
        @(posedge aclk) disable iff (!aresetn)
        wr_w1c && !link.alarm_change |=> !far_end_chg;
    endproperty
    a_w1c: assert property (p_w1c) else $error("Write of one did not clear."); // RL10

    property p_irq_drop;
        @(posedge aclk) disable iff (!aresetn)
        !far_end_chg |=> !irq;
    endproperty
    a_irq_drop: assert property (p_irq_drop) else $error("Stray interrupt."); // RL11

    // The counter may only move on the cycle that follows an interval end.
    property p_cnt_hold;
        @(posedge aclk) disable iff (!aresetn)
        !link.interval_tick |-> $stable(link.count);
    endproperty
    a_cnt_hold: assert property (p_cnt_hold) else $error("Count moved mid-interval."); // RL1

    // A state change lands on an interval end with the counter at one of its end points.
    property p_chg_end;
        @(posedge aclk) disable iff (!aresetn)
        link.alarm_change |-> link.interval_tick
            && link.count == (link.far_end_alarm ? CW'(DECLARE_COUNT) : CW'(0));
    endproperty
    a_chg_end: assert property (p_chg_end) else $error("Alarm off end point."); // RL2 RL3
endmodule : dyam_monitor

// ===== bench/dyam_cpu.sv
// Bus master model of the processor that reads and writes the alarm registers.
`timescale 1ns/1ps
module dyam_cpu (
    // Clock.
    input wire logic aclk,
    // Write channels.
    output logic [7:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input dyam_pkg::dyam_resp_e bresp,
    input wire logic bvalid,
    output logic bready,
    // Read channels.
    output logic [7:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input dyam_pkg::dyam_resp_e rresp,
    input wire logic rvalid,
    output logic rready
);
    import dyam_pkg::*;
    // ----------------------------------------------------------------
    // Bus cycles
    // ----------------------------------------------------------------
    // Everything idle at time zero.
    initial begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
    end
    // A taken address or data word is inverted, so a slave that samples late sees junk, not the old value.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      output dyam_resp_e r);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) begin
                awvalid <= 1'b0;
                awaddr <= ~a;
            end
            if (wvalid && wready) begin
                wvalid <= 1'b0;
                wdata <= ~d;
            end
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask : wr
    // Read: rready is held from the start until rvalid is sampled high.
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output dyam_resp_e r);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) begin
                arvalid <= 1'b0;
                araddr <= ~a;
            end
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : rd
endmodule : dyam_cpu

// ===== bench/dyam_monitor_test.sv
// Self-checking testbench of the far-end alarm monitor.
`timescale 1ns/1ps
`include "dyam_map.svh"
module dyam_monitor_test;
    import dyam_pkg::*;
    // Short interval and threshold keep the run brief.
    localparam int N = 8;
    localparam int D = 4;
    localparam logic [7:0] ST = `DYAM_ADDR_ALARM_ERROR_STATUS;
    logic aclk, aresetn, pattern_seen, irq;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, seed;
    logic [3:0] wstrb;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    dyam_resp_e bresp, rresp, sr;
    logic pat_on, cur_flag, prev_flag, malarm, mchg, cor, en, gate;
    int cyc, mcnt, failures, comparisons;

    dyam_monitor #(.INTERVAL_CYCLES(N), .DECLARE_COUNT(D), .ADDR_W(8)) u_dut (
        .aclk(aclk), .aresetn(aresetn), .pattern_seen(pattern_seen),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .irq(irq));
    dyam_cpu u_cpu (
        .aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

    // ----------------------------------------------------------------
    // Expectation helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [31:0] st_exp();
        return {26'h0, malarm, 4'h0, mchg};
    endfunction : st_exp

    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    // Pattern source and interval model. Pulses stay in the middle of each interval so a
    // one-cycle doubt about where the design's timer starts cannot move them across a border.
    always @(posedge aclk) begin
        seed = lfsr(seed);
        if (!aresetn) begin
            cyc <= 0;
            cur_flag <= 1'b0;
            prev_flag <= 1'b0;
            pattern_seen <= 1'b0;
            mcnt = 0;
            malarm = 1'b0;
            mchg = 1'b0;
        end else begin
            cyc <= cyc + 1;
            if (cyc % N == 0) begin
                prev_flag <= cur_flag;
                cur_flag <= pat_on;
            end
            pattern_seen <= cur_flag && (cyc % N == 4 || (cyc % N inside {[2:5]} && seed[3]));
            if (cyc % N == 2) begin
                mcnt = prev_flag ? (mcnt < D ? mcnt + 1 : D) : (mcnt > 0 ? mcnt - 1 : 0);
                if ((mcnt == D && !malarm) || (mcnt == 0 && malarm)) begin
                    malarm = ~malarm;
                    mchg = 1'b1;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Bus tasks and checking
    // ----------------------------------------------------------------
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    // Bus traffic starts mid-interval, away from the model's update point.
    task automatic sync();
        do @(posedge aclk); while (cyc % N != 4);
    endtask : sync
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input dyam_resp_e er);
        dyam_resp_e r;
        sync();
        u_cpu.wr(a, d, 4'hF, r);
        check("bresp", 32'(r), 32'(er));
        if (a == `DYAM_ADDR_IRQ_CONTROL) cor = d[0];
        if (a == `DYAM_ADDR_BLOCK_IRQ_ENABLE) gate = d[1];
        if (a == `DYAM_ADDR_ALARM_ERROR_IRQ_ENABLE) en = d[0];
        if (a == ST && d[0]) mchg = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input dyam_resp_e er);
        logic [31:0] d;
        dyam_resp_e r;
        sync();
        check("irq", {31'h0, irq}, {31'h0, mchg & en & gate});
        if (a == ST) e = st_exp();
        u_cpu.rd(a, d, r);
        check("rdata", d, e);
        check("rresp", 32'(r), 32'(er));
        if (a == ST && cor) mchg = 1'b0;
    endtask : rd
    task automatic stage(input logic on, input int n);
        pat_on = on;
        repeat (n) rd(ST, 32'h0, DYAM_RESP_OKAY);
    endtask : stage
    task automatic give_verdict();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : give_verdict

    // The whole run needs near 1000 cycles; the limit leaves wide room.
    initial begin
        repeat (20000) @(posedge aclk);
        failures++;
        give_verdict();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        {aresetn, pat_on, cor, en, gate} = '0;
        seed = 32'h31A5;
        failures = 0;
        comparisons = 0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 4; i++) rd(8'(4 * i), 32'h0, DYAM_RESP_OKAY);
        rd(8'h10, 32'h0, DYAM_RESP_SLVERR);
        wr(8'h10, seed, DYAM_RESP_SLVERR);
        // Random round trips through the read-write registers.
        for (int i = 0; i < 3; i++) begin
            logic [7:0] a;
            logic [31:0] v;
            a = 8'(i == 2 ? 12 : 4 * i);
            v = seed;
            wr(a, v, DYAM_RESP_OKAY);
            rd(a, {24'h0, v[7:0]}, DYAM_RESP_OKAY);
        end
        wr(`DYAM_ADDR_IRQ_CONTROL, 32'h0, DYAM_RESP_OKAY);
        wr(`DYAM_ADDR_BLOCK_IRQ_ENABLE, 32'h2, DYAM_RESP_OKAY);
        wr(`DYAM_ADDR_ALARM_ERROR_IRQ_ENABLE, 32'h1, DYAM_RESP_OKAY);
        // A write with byte lane 0 off must leave the register alone.
        sync();
        u_cpu.wr(`DYAM_ADDR_ALARM_ERROR_IRQ_ENABLE, 32'h0, 4'hE, sr);
        check("bresp", 32'(sr), 32'(DYAM_RESP_OKAY));
        rd(`DYAM_ADDR_ALARM_ERROR_IRQ_ENABLE, 32'h1, DYAM_RESP_OKAY);
        // Declare, clear by write, dip without removal, then remove.
        stage(1'b1, D + 2);
        wr(ST, 32'h1, DYAM_RESP_OKAY);
        stage(1'b0, 2);
        stage(1'b1, 2);
        stage(1'b0, D + 3);
        // Every combination of the change enable and the group gate.
        for (int i = 0; i < 4; i++) begin
            wr(`DYAM_ADDR_ALARM_ERROR_IRQ_ENABLE, 32'(i & 1), DYAM_RESP_OKAY);
            wr(`DYAM_ADDR_BLOCK_IRQ_ENABLE, 32'(i & 2), DYAM_RESP_OKAY);
            stage(1'b0, 1);
        end
        wr(`DYAM_ADDR_IRQ_CONTROL, 32'h1, DYAM_RESP_OKAY);
        stage(1'b0, 2);
        // Random runs of flagged intervals mixed with random register writes.
        for (int i = 0; i < 60; i++) begin
            if (seed[7:5] == 3'h0) pat_on = ~pat_on;
            if (seed[9:8] == 2'h0) wr(8'(4 * seed[11:10]), seed, DYAM_RESP_OKAY);
            stage(pat_on, 1);
        end
        give_verdict();
    end
endmodule : dyam_monitor_test
